// *** tape_velocity_checker_test.sv ***
// bench for the tape velocity checker: table of tach bursts, then bus cases
// assumes tvc_tape_unit drives tach and model pins; short tolerance window
`timescale 1ns/1ps
module tape_velocity_checker_test;
	import tvc_pkg::*;
	typedef struct packed {
		logic [1:0] m;
		logic [7:0] nb;
		logic [7:0] ng;
		logic w;
		logic [15:0] len;
		logic [2:0] ex;
	} tvc_row_t;
	logic clk = 1'b0, rst = 1'b1, tach, gap = 1'b0, nrzi = 1'b0, gcr = 1'b0;
	logic wop = 1'b0, done = 1'b0, dseen = 1'b0, rsm = 1'b0;
	logic wr = 1'b0, rd = 1'b0, vchk, vchg, noblk, irq;
	logic [3:0] model;
	logic [1:0] addr = 2'h0;
	logic [2:0] wdata = 3'h0, rdata;
	logic [15:0] len = 16'h0000;
	int num_errors = 0, checks_done = 0, cyc = 0;
	tvc_row_t rows [11] = '{
		'{2'h0, 8'h1E, 8'h00, 1'b0, 16'h0000, 3'h2},
		'{2'h2, 8'h28, 8'h00, 1'b0, 16'h0000, 3'h2},
		'{2'h0, 8'h00, 8'h1E, 1'b0, 16'h0000, 3'h0},
		'{2'h0, 8'h04, 8'h1E, 1'b1, 16'h012C, 3'h0},
		'{2'h2, 8'h01, 8'h1E, 1'b1, 16'h0384, 3'h0},
		'{2'h0, 8'h06, 8'h0A, 1'b1, 16'h00DD, 3'h1},
		'{2'h0, 8'h06, 8'h0A, 1'b1, 16'h00DC, 3'h0},
		'{2'h1, 8'h06, 8'h0A, 1'b1, 16'h0079, 3'h1},
		'{2'h1, 8'h06, 8'h0A, 1'b1, 16'h0078, 3'h0},
		'{2'h2, 8'h02, 8'h0A, 1'b1, 16'h0339, 3'h1},
		'{2'h2, 8'h02, 8'h0A, 1'b1, 16'h0338, 3'h0}};
	tvc_checker #(.PER_MIN(20'h00008), .PER_MAX(20'h00010)) uut (.CLK(clk),
		.RST(rst), .TACH(tach), .GAP_ACTIVE(gap), .MODEL_BITS(model),
		.NRZI_SEL(nrzi), .WRITE_OP(wop), .RECORD_LEN(len), .OP_DONE(done),
		.DATA_SEEN(dseen), .RECORD_START_MARK(rsm), .WR(wr), .RD(rd),
		.ADDR(addr), .WDATA(wdata), .RDATA(rdata), .SENSE_VEL_CHECK(vchk),
		.SENSE_VEL_CHANGE(vchg), .SENSE_NO_BLOCK(noblk), .IRQ(irq));
	tvc_tape_unit u_tape (.CLK(clk), .GCR(gcr), .TACH(tach),
		.MODEL_BITS(model));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task chk(input logic [2:0] got, input logic [2:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bw(input logic [1:0] a, input logic [2:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task br(input logic [1:0] a, input logic [2:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task ck_irq(input logic e);
		repeat (2) @(posedge clk);
		#1 chk({2'h0, irq}, {2'h0, e});
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ceiling well above the longest table row times the row count
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			results;
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 chk({noblk, vchk, vchg}, 3'h0);
		br(2'h0, 3'h0);
		$display("reset test done");
		bw(2'h1, 3'h7);
		foreach (rows[i]) begin
			gcr <= rows[i].m == 2'h2;
			nrzi <= rows[i].m == 2'h1;
			wop <= rows[i].w;
			len <= rows[i].len;
			repeat (4) @(posedge clk);
			gap <= 1'b1;
			repeat (6) @(posedge clk);
			u_tape.burst(rows[i].nb, rows[i].ng);
			repeat (10) @(posedge clk);
			gap <= 1'b0;
			wop <= 1'b0;
			#1 chk({noblk, vchk, vchg}, rows[i].ex);
			chk({2'h0, irq}, {2'h0, |rows[i].ex});
			br(2'h0, rows[i].ex);
			bw(2'h0, 3'h7);
			$display("row %0d done", i);
		end
		// status is sticky, so only the last pass may raise the flag
		for (int k = 2; k >= 0; k--) begin
			@(posedge clk);
			wop <= 1'b1;
			dseen <= k == 1;
			rsm <= k == 2;
			@(posedge clk);
			dseen <= 1'b0;
			rsm <= 1'b0;
			done <= 1'b1;
			@(posedge clk);
			done <= 1'b0;
			wop <= 1'b0;
			repeat (2) @(posedge clk);
			#1 chk({noblk, vchk, vchg}, (k == 0) ? 3'h4 : 3'h0);
		end
		$display("no block test done");
		bw(2'h1, 3'h3);
		ck_irq(1'b0);
		bw(2'h1, 3'h4);
		ck_irq(1'b1);
		bw(2'h2, 3'h7);
		br(2'h2, 3'h0);
		br(2'h1, 3'h4);
		bw(2'h0, 3'h3);
		br(2'h0, 3'h4);
		bw(2'h0, 3'h4);
		ck_irq(1'b0);
		br(2'h0, 3'h0);
		$display("bus and interrupt test done");
		// second reset in mid-run: flag, mask and interrupt all drop
		@(posedge clk);
		wop <= 1'b1;
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		wop <= 1'b0;
		ck_irq(1'b1);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 chk({noblk, vchk, vchg}, 3'h0);
		chk({2'h0, irq}, 3'h0);
		br(2'h1, 3'h0);
		$display("mid-run reset test done");
		results;
	end
endmodule

// *** tvc_checker.sv ***
// velocity supervision: tach pulse timing checks after the gap window opens
// assumes tach, gap and model inputs are asynchronous pins; others same clock
//
// Contract
// R1 - PE/NRZI: ignore first four tach pulses after gap window opens
// R2 - PE/NRZI: 24 pulses without four good in a row sets velocity check
// R3 - write check only PE over 220 or NRZI over 120 bytes; bad sets change
// R4 - GCR: skip the first tach pulse after gap window opens
// R5 - GCR: 32 half pulses without one good full pulse sets velocity check
// R6 - GCR write check only over 824 bytes; bad pulse sets velocity change
// R7 - write or tape mark write ending with no data or record start flags
// R8 - tape unit reports model on bits 4-7; bit 4 means 6250 capability
// R9 - tach pulse good when period sits inside a configurable window
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module tvc_checker #(
	parameter logic [tvc_pkg::TVC_PER_W-1:0] PER_MIN =
		tvc_pkg::TVC_PER_MIN,
	parameter logic [tvc_pkg::TVC_PER_W-1:0] PER_MAX =
		tvc_pkg::TVC_PER_MAX
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic TACH,
	input wire logic GAP_ACTIVE,
	input wire logic [3:0] MODEL_BITS,
	input wire logic NRZI_SEL,
	input wire logic WRITE_OP,
	input wire logic [tvc_pkg::TVC_LEN_W-1:0] RECORD_LEN,
	input wire logic OP_DONE,
	input wire logic DATA_SEEN,
	input wire logic RECORD_START_MARK,
	input wire logic WR,
	input wire logic RD,
	input wire logic [1:0] ADDR,
	input wire logic [tvc_pkg::TVC_ST_W-1:0] WDATA,
	output logic [tvc_pkg::TVC_ST_W-1:0] RDATA,
	output logic SENSE_VEL_CHECK,
	output logic SENSE_VEL_CHANGE,
	output logic SENSE_NO_BLOCK,
	output logic IRQ
);
	import tvc_pkg::*;

	localparam logic [1:0] A_STATUS = 2'h0;
	localparam logic [1:0] A_MASK = 2'h1;

	// two-flop synchronisers; stage one feeds only stage two
	logic [5:0] s1_r, s2_r, s3_r;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s1_r <= 6'h00;
			s2_r <= 6'h00;
			s3_r <= 6'h00;
		end else begin
			s1_r <= {TACH, GAP_ACTIVE, MODEL_BITS};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	logic tach_s, gap_s, gcr_s;
	assign tach_s = s2_r[5];
	assign gap_s = s2_r[4];
	assign gcr_s = s2_r[TVC_MODEL_GCR_BIT]; // R8
	logic tach_edge, tach_half, gap_rise;
	assign tach_edge = tach_s & ~s3_r[5];
	assign tach_half = tach_s ^ s3_r[5];
	assign gap_rise = gap_s & ~s3_r[4];

	tvc_mode_t mode;
	always_comb begin
		if (gcr_s)
			mode = TVC_MODE_GCR;
		else if (NRZI_SEL)
			mode = TVC_MODE_NRZI;
		else
			mode = TVC_MODE_PE;
	end

	logic [TVC_PER_W-1:0] per_r, per_nxt;
	logic [TVC_CNT_W-1:0] skip_r, skip_nxt, cnt_r, cnt_nxt;
	logic [2:0] run_r, run_nxt;
	logic done_r, done_nxt, seen_r, seen_nxt, prime_r, prime_nxt;
	logic [TVC_ST_W-1:0] st_r, st_nxt, mask_r, mask_nxt, rd_r, rd_nxt;
	logic ev_chk, ev_chg, ev_nob, in_tol, long_rec, eval;
	logic [TVC_CNT_W-1:0] skip_lim;

	// a period is only valid once a full edge-to-edge interval was timed
	assign in_tol = prime_r && per_r >= PER_MIN && per_r <= PER_MAX; // R9
	assign skip_lim = (mode == TVC_MODE_GCR) ? TVC_CNT_W'(TVC_GCR_SKIP)
		: TVC_CNT_W'(TVC_PE_SKIP); // R1 R4
	assign eval = gap_s && tach_edge && skip_r >= skip_lim;

	always_comb begin
		case (mode)
			TVC_MODE_GCR:
				long_rec = RECORD_LEN > TVC_LEN_W'(TVC_GCR_MIN_BYTES); // R6
			TVC_MODE_NRZI:
				long_rec = RECORD_LEN > TVC_LEN_W'(TVC_NRZI_MIN_BYTES); // R3
			default:
				long_rec = RECORD_LEN > TVC_LEN_W'(TVC_PE_MIN_BYTES); // R3
		endcase
	end

	always_comb begin
		per_nxt = per_r;
		skip_nxt = skip_r;
		cnt_nxt = cnt_r;
		run_nxt = run_r;
		done_nxt = done_r;
		prime_nxt = prime_r;
		ev_chk = 1'b0;
		ev_chg = 1'b0;
		if (per_r != {TVC_PER_W{1'b1}})
			per_nxt = per_r + TVC_PER_W'(1);
		if (gap_rise) begin
			skip_nxt = '0;
			cnt_nxt = '0;
			run_nxt = '0;
			done_nxt = 1'b0;
			prime_nxt = 1'b0;
		end else if (gap_s) begin
			if (tach_edge) begin
				per_nxt = '0;
				prime_nxt = 1'b1;
				if (skip_r < skip_lim)
					skip_nxt = skip_r + TVC_CNT_W'(1); // R1 R4
			end
			if (eval && WRITE_OP && long_rec && !in_tol)
				ev_chg = 1'b1; // R3 R6
			if (!done_r) begin
				if (mode == TVC_MODE_GCR) begin
					// half pulses counted on both tach edges after the skip
					if (eval && in_tol)
						done_nxt = 1'b1; // R5
					else if (tach_half && skip_r >= skip_lim) begin
						cnt_nxt = cnt_r + TVC_CNT_W'(1);
						if (cnt_nxt == TVC_CNT_W'(TVC_GCR_HALF_LIMIT)) begin
							ev_chk = 1'b1; // R5
							done_nxt = 1'b1;
						end
					end
				end else if (eval) begin
					run_nxt = in_tol ? run_r + 3'h1 : 3'h0;
					cnt_nxt = cnt_r + TVC_CNT_W'(1);
					if (run_nxt == 3'(TVC_PE_RUN))
						done_nxt = 1'b1; // R2
					else if (cnt_nxt == TVC_CNT_W'(TVC_PE_LIMIT)) begin
						ev_chk = 1'b1; // R2
						done_nxt = 1'b1;
					end
				end
			end
		end
	end

	// no-block detect across one write or tape mark write
	always_comb begin
		seen_nxt = seen_r;
		ev_nob = 1'b0;
		if (OP_DONE) begin
			ev_nob = WRITE_OP && !seen_r && !DATA_SEEN
				&& !RECORD_START_MARK; // R7
			seen_nxt = 1'b0;
		// marks seen outside a write must not hide a missing block
		end else if (!WRITE_OP)
			seen_nxt = 1'b0;
		else if (DATA_SEEN || RECORD_START_MARK)
			seen_nxt = 1'b1;
	end

	// sticky status; a set in the clearing cycle wins
	always_comb begin
		logic [TVC_ST_W-1:0] ev;
		ev = '0;
		ev[TVC_ST_VCHG] = ev_chg;
		ev[TVC_ST_VCHK] = ev_chk;
		ev[TVC_ST_NOBLK] = ev_nob;
		st_nxt = st_r;
		mask_nxt = mask_r;
		if (WR && ADDR == A_STATUS)
			st_nxt = st_r & ~WDATA;
		if (WR && ADDR == A_MASK)
			mask_nxt = WDATA;
		st_nxt = st_nxt | ev;
		rd_nxt = '0;
		if (RD && ADDR == A_STATUS)
			rd_nxt = st_r;
		else if (RD && ADDR == A_MASK)
			rd_nxt = mask_r;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			per_r <= '0;
			skip_r <= '0;
			cnt_r <= '0;
			run_r <= '0;
			done_r <= 1'b0;
			prime_r <= 1'b0;
			seen_r <= 1'b0;
			st_r <= '0;
			mask_r <= '0;
			rd_r <= '0;
			IRQ <= 1'b0;
		end else begin
			per_r <= per_nxt;
			skip_r <= skip_nxt;
			cnt_r <= cnt_nxt;
			run_r <= run_nxt;
			done_r <= done_nxt;
			prime_r <= prime_nxt;
			seen_r <= seen_nxt;
			st_r <= st_nxt;
			mask_r <= mask_nxt;
			rd_r <= rd_nxt;
			IRQ <= |(st_nxt & mask_nxt);
		end
	end
	assign RDATA = rd_r;
	assign SENSE_VEL_CHANGE = st_r[TVC_ST_VCHG];
	assign SENSE_VEL_CHECK = st_r[TVC_ST_VCHK];
	assign SENSE_NO_BLOCK = st_r[TVC_ST_NOBLK];

	// every check runs on the core clock and sleeps while reset is high
	a_pe_limit_flag: assert property ( // R2
		@(posedge CLK) disable iff (RST)
		mode != TVC_MODE_GCR && ev_chk
		|-> cnt_nxt == TVC_CNT_W'(TVC_PE_LIMIT))
		else $error("pe velocity check at wrong count");
	a_pe_skip_first: assert property ( // R1
		@(posedge CLK) disable iff (RST)
		mode != TVC_MODE_GCR && eval
		|-> skip_r == TVC_CNT_W'(TVC_PE_SKIP))
		else $error("pe pulse evaluated too early");
	a_gcr_skip_one: assert property ( // R4
		@(posedge CLK) disable iff (RST)
		mode == TVC_MODE_GCR && eval
		|-> skip_r >= TVC_CNT_W'(TVC_GCR_SKIP))
		else $error("gcr first pulse evaluated");
	a_gcr_half_limit: assert property ( // R5
		@(posedge CLK) disable iff (RST)
		mode == TVC_MODE_GCR && ev_chk
		|=> cnt_r == TVC_CNT_W'(TVC_GCR_HALF_LIMIT) && SENSE_VEL_CHECK)
		else $error("gcr velocity check wrong");
	a_chg_len_gate: assert property ( // R3
		@(posedge CLK) disable iff (RST)
		ev_chg |-> WRITE_OP && long_rec)
		else $error("velocity change outside long write");
	a_gcr_len: assert property ( // R6
		@(posedge CLK) disable iff (RST)
		mode == TVC_MODE_GCR && ev_chg
		|-> RECORD_LEN > TVC_LEN_W'(TVC_GCR_MIN_BYTES))
		else $error("gcr change on short record");
	a_noblk_set: assert property ( // R7
		@(posedge CLK) disable iff (RST)
		OP_DONE && WRITE_OP && !seen_r && !DATA_SEEN && !RECORD_START_MARK
		|=> SENSE_NO_BLOCK)
		else $error("no block flag missing");
	a_tol_window: assert property ( // R9
		@(posedge CLK) disable iff (RST)
		in_tol |-> per_r >= PER_MIN && per_r <= PER_MAX)
		else $error("tolerance window broken");
	// the level must follow the stored bits, not lag a cycle behind them
	a_irq_level: assert property (
		@(posedge CLK) disable iff (RST)
		IRQ == |(st_r & mask_r))
		else $error("interrupt level wrong");
	a_closed_quiet: assert property ( // R1
		@(posedge CLK) disable iff (RST)
		!gap_s |-> !ev_chk && !ev_chg)
		else $error("pulse judged with the gap window shut");
	a_gap_restart: assert property ( // R1
		@(posedge CLK) disable iff (RST)
		gap_rise |=> skip_r == '0 && cnt_r == '0 && !done_r)
		else $error("gap window opened without a fresh count");

	// last counted pulse of a window that never found a good run
	sequence s_pe_last_bad;
		mode != TVC_MODE_GCR && gap_s && !gap_rise && !done_r && eval
			&& !in_tol && cnt_r == TVC_CNT_W'(TVC_PE_LIMIT - 1);
	endsequence
	// pulse that completes the good run
	sequence s_pe_fourth_good;
		mode != TVC_MODE_GCR && gap_s && !gap_rise && !done_r && eval
			&& in_tol && run_r == 3'(TVC_PE_RUN - 1);
	endsequence
	// last half pulse before the limit, with no good full pulse on it
	sequence s_gcr_last_half;
		mode == TVC_MODE_GCR && gap_s && !gap_rise && !done_r
			&& tach_half && skip_r >= skip_lim && !(eval && in_tol)
			&& cnt_r == TVC_CNT_W'(TVC_GCR_HALF_LIMIT - 1);
	endsequence
	// a trip raised and then seen on the sense output
	sequence s_chk_raised;
		ev_chk ##1 SENSE_VEL_CHECK;
	endsequence
	a_pe_trip_count: assert property ( // R2
		@(posedge CLK) disable iff (RST)
		s_pe_last_bad |-> ev_chk)
		else $error("pe velocity check missed at limit");
	a_pe_good_run: assert property ( // R2
		@(posedge CLK) disable iff (RST)
		s_pe_fourth_good |-> !ev_chk ##1 done_r)
		else $error("pe good run did not end checking");
	a_gcr_trip_count: assert property ( // R5
		@(posedge CLK) disable iff (RST)
		s_gcr_last_half |-> ev_chk)
		else $error("gcr velocity check missed at limit");
	a_chk_sticky: assert property ( // R2
		@(posedge CLK) disable iff (RST)
		s_chk_raised ##0 !(WR && ADDR == A_STATUS) |=> SENSE_VEL_CHECK)
		else $error("velocity check flag lost");
endmodule

// *** tvc_pkg.sv ***
// package for the tape velocity checker: modes, limits and counts
// assumes a 200 MHz core clock; tolerance windows are configurable defaults
package tvc_pkg;
	typedef enum logic [1:0] {TVC_MODE_PE, TVC_MODE_NRZI, TVC_MODE_GCR}
		tvc_mode_t;
	localparam int TVC_PE_SKIP = 4;
	localparam int TVC_PE_LIMIT = 24;
	localparam int TVC_PE_RUN = 4;
	localparam int TVC_GCR_SKIP = 1;
	localparam int TVC_GCR_HALF_LIMIT = 32;
	localparam int TVC_PE_MIN_BYTES = 220;
	localparam int TVC_NRZI_MIN_BYTES = 120;
	localparam int TVC_GCR_MIN_BYTES = 824;
	localparam int TVC_MODEL_GCR_BIT = 0;
	localparam int TVC_CNT_W = 6;
	localparam int TVC_PER_W = 20;
	localparam int TVC_LEN_W = 16;
	localparam logic [TVC_PER_W-1:0] TVC_PER_MIN = 20'h01000;
	localparam logic [TVC_PER_W-1:0] TVC_PER_MAX = 20'h04000;
	localparam int TVC_ST_VCHG = 0;
	localparam int TVC_ST_VCHK = 1;
	localparam int TVC_ST_NOBLK = 2;
	localparam int TVC_ST_W = 3;
endpackage

// *** tvc_tape_unit.sv ***
// tape unit model: capstan tach pulses and model bits on the inbound bus
// assumes the bench calls burst only while the gap window is open
`timescale 1ns/1ps
module tvc_tape_unit #(
	parameter int GOOD_PER = 12,
	parameter int BAD_PER = 5
) (
	input wire logic CLK,
	input wire logic GCR,
	output logic TACH,
	output logic [3:0] MODEL_BITS
);
	// speed bits arbitrary; only the density bit steers the checker
	assign MODEL_BITS = {3'h3, GCR};
	// tach rests low between bursts, as a stopped capstan would
	initial TACH = 1'b0;
	// low time first, so each rise sits one full period after the last
	task automatic burst(input int nb, input int ng);
		int per;
		for (int i = 0; i < nb + ng; i++) begin
			per = (i < nb) ? BAD_PER : GOOD_PER;
			repeat (per - 2) @(posedge CLK);
			TACH <= 1'b1;
			repeat (2) @(posedge CLK);
			TACH <= 1'b0;
		end
	endtask
endmodule
